// ===== src/eeprom_slave_pkg.sv
package eeprom_slave_pkg;

    // system clock and write cycle timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int TWR_MAX_NS = 5000000;
    // longest time: rounds down to whole cycles
    localparam int TWR_CYC = TWR_MAX_NS / CLK_PERIOD_NS;

    // array geometry
    localparam int ADDR_W = 11;
    localparam int PAGE_W = 4;
    localparam int BLK_W = 3;
    localparam int PAGE_BYTES = 16;

    // bit counter marks for an eight-bit byte
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_DONE = 4'h8;

    // slave address field positions
    localparam int SA_CODE_HI = 7;
    localparam int SA_CODE_LO = 4;
    localparam int SA_BLK_HI = 3;
    localparam int SA_BLK_LO = 1;
    localparam int SA_DIR = 0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX = 3'b001,
        ST_ACK = 3'b010,
        ST_TX = 3'b011,
        ST_MACK = 3'b100,
        ST_WAIT = 3'b101
    } state_e;

    typedef enum logic [1:0] {
        K_SLAVE = 2'b00,
        K_WADDR = 2'b01,
        K_WDATA = 2'b10
    } kind_e;

    // one sample of the bus pins
    typedef struct packed {
        logic scl;
        logic sda;
        logic wp;
    } pins_s;

endpackage

// ===== src/eeprom_slave.sv
`timescale 1ns/100ps
// How it works
// - falling data while clock high is a start; commands need one first.
// - transfers are eight-bit bytes each followed by a receiver acknowledge.
// - rising data while clock high is a stop ending the command.
// - transmitter releases data after eight bits; receiver pulls low in the ninth.
// - matching slave address after start is acknowledged low.
// - each word-address and write-data byte is acknowledged low; a data byte cancelled by write protect is not.
// - read byte acked low sends next; high ends transfer, awaits stop.
// - upper four slave address bits must equal the device-type code.
// - lowest slave address bit: zero write, one read.
// - slave address bits three to one pick the block.
// - during programming every command is ignored and nothing acknowledged.
// - programming starts only at stop right after a complete data byte.
// - programming lasts at most 5 ms for a whole page.
// - page write advances low four address bits, wrapping within page.
// - write protect high blocks all writes; low allows them.
// - random read returns the byte at the address just set.
// - current read returns the byte after the last one accessed.
// - polling slave address is acked only once programming is done.
// - protect raised from first data byte end to stop cancels write.
// - protect level is ignored before last bit of first data byte.
// - start then stop during command input aborts it.
// - read aborted by start-stop leaves the pointer undefined.
// - dummy clocks plus starts recover the slave to a fresh command.
module eeprom_slave #(
    parameter logic [3:0] DEV_CODE = 4'h5, // arbitrary device-type code
    parameter int TWR_CYC = eeprom_slave_pkg::TWR_CYC
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic wp_in,
    output logic sda_out,
    output logic sda_oe_n,
    output logic prog_busy
);

    localparam int CNT_W = $clog2(TWR_CYC + 1);
    localparam int AW = eeprom_slave_pkg::ADDR_W;
    localparam int PW = eeprom_slave_pkg::PAGE_W;

    eeprom_slave_pkg::pins_s sync1_r;
    eeprom_slave_pkg::pins_s sync2_r;
    eeprom_slave_pkg::pins_s prev_r;
    eeprom_slave_pkg::state_e st_r;
    eeprom_slave_pkg::kind_e kind_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] tx_r;
    logic drive_r;
    logic [eeprom_slave_pkg::BLK_W-1:0] blk_r;
    logic rd_r;
    logic [AW-1:0] addr_r;
    logic mack_r;
    logic pending_r;
    logic armed_r;
    logic busy_r;
    logic [CNT_W-1:0] twr_cnt_r;
    logic [PW:0] idx_r;
    logic [AW-PW-1:0] prog_page_r;
    logic [eeprom_slave_pkg::PAGE_BYTES-1:0] valid_r;
    logic [7:0] mem [0:(1<<AW)-1];
    logic [7:0] page_buf [0:eeprom_slave_pkg::PAGE_BYTES-1];
    logic [7:0] mem_q;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic byte_end;
    logic buf_we;
    logic prog_go;
    logic wp_cancel;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    // two flops per pin, a third only for edge finding
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            sync1_r <= '{scl: 1'b1, sda: 1'b1, wp: 1'b0};
            sync2_r <= '{scl: 1'b1, sda: 1'b1, wp: 1'b0};
            prev_r <= '{scl: 1'b1, sda: 1'b1, wp: 1'b0};
        end
        else
        begin
            sync1_r <= '{scl: scl_in, sda: sda_in, wp: wp_in};
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    // bus events; start and stop need clock high, so never meet a clock edge
    assign scl_rise = sync2_r.scl && !prev_r.scl;
    assign scl_fall = !sync2_r.scl && prev_r.scl;
    assign start_det = sync2_r.scl && prev_r.scl && prev_r.sda && !sync2_r.sda;
    assign stop_det = sync2_r.scl && prev_r.scl && !prev_r.sda && sync2_r.sda;
    assign byte_end = scl_fall && (st_r == eeprom_slave_pkg::ST_RX)
        && (bit_cnt_r == eeprom_slave_pkg::BIT_DONE);
    // a cancelled byte must not land in the page buffer
    assign buf_we = byte_end && (kind_r == eeprom_slave_pkg::K_WDATA) && !wp_cancel;
    // the stop sits in the high phase of the next byte's first bit: one rise seen
    assign prog_go = stop_det && (st_r == eeprom_slave_pkg::ST_RX) && pending_r
        && (kind_r == eeprom_slave_pkg::K_WDATA) && (bit_cnt_r == 4'h1);
    assign wp_cancel = armed_r && sync2_r.wp;
    assign mem_q = mem[addr_r];

    // open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe_n = !drive_r;
    assign prog_busy = busy_r;

    // command sequencer
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r <= eeprom_slave_pkg::ST_IDLE;
            kind_r <= eeprom_slave_pkg::K_SLAVE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            tx_r <= 8'h00;
            drive_r <= 1'b0;
            blk_r <= 3'h0;
            rd_r <= 1'b0;
            addr_r <= 11'h000;
            mack_r <= 1'b0;
            pending_r <= 1'b0;
            armed_r <= 1'b0;
        end
        else if (stop_det)
        begin
            // also the start-then-stop abort; pointer kept as is
            st_r <= eeprom_slave_pkg::ST_IDLE;
            drive_r <= 1'b0;
            pending_r <= 1'b0;
            armed_r <= 1'b0;
        end
        else if (start_det)
        begin
            // a start restarts unless programming, which is what recovers a stuck slave
            if (busy_r)
            begin
                st_r <= eeprom_slave_pkg::ST_IDLE;
            end
            else
            begin
                st_r <= eeprom_slave_pkg::ST_RX;
            end
            kind_r <= eeprom_slave_pkg::K_SLAVE;
            bit_cnt_r <= 4'h0;
            drive_r <= 1'b0;
            pending_r <= 1'b0;
            armed_r <= 1'b0;
        end
        else if (wp_cancel)
        begin
            // forced end: drop the buffered bytes, back to standby
            st_r <= eeprom_slave_pkg::ST_IDLE;
            drive_r <= 1'b0;
            pending_r <= 1'b0;
            armed_r <= 1'b0;
        end
        else
        begin
            case (st_r)
                eeprom_slave_pkg::ST_RX:
                begin
                    if (scl_rise && (bit_cnt_r != eeprom_slave_pkg::BIT_DONE))
                    begin
                        shift_r <= {shift_r[6:0], sync2_r.sda};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        // protect counts from the rise taking the last data bit
                        if ((kind_r == eeprom_slave_pkg::K_WDATA)
                            && (bit_cnt_r == eeprom_slave_pkg::BIT_LAST))
                        begin
                            armed_r <= 1'b1;
                        end
                    end
                    else if (byte_end)
                    begin
                        case (kind_r)
                            eeprom_slave_pkg::K_SLAVE:
                            begin
                                if (shift_r[eeprom_slave_pkg::SA_CODE_HI:
                                    eeprom_slave_pkg::SA_CODE_LO] == DEV_CODE)
                                begin
                                    st_r <= eeprom_slave_pkg::ST_ACK;
                                    drive_r <= 1'b1;
                                    blk_r <= shift_r[eeprom_slave_pkg::SA_BLK_HI:
                                        eeprom_slave_pkg::SA_BLK_LO];
                                    rd_r <= shift_r[eeprom_slave_pkg::SA_DIR];
                                end
                                else
                                begin
                                    st_r <= eeprom_slave_pkg::ST_WAIT;
                                end
                            end
                            eeprom_slave_pkg::K_WADDR:
                            begin
                                addr_r <= {blk_r, shift_r};
                                st_r <= eeprom_slave_pkg::ST_ACK;
                                drive_r <= 1'b1;
                            end
                            default:
                            begin
                                // only the low bits move, so excess bytes wrap
                                addr_r[PW-1:0] <= addr_r[PW-1:0] + 4'h1;
                                pending_r <= 1'b1;
                                st_r <= eeprom_slave_pkg::ST_ACK;
                                drive_r <= 1'b1;
                            end
                        endcase
                    end
                end
                eeprom_slave_pkg::ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        bit_cnt_r <= 4'h0;
                        if ((kind_r == eeprom_slave_pkg::K_SLAVE) && rd_r)
                        begin
                            // current read: pointer already holds last + 1
                            st_r <= eeprom_slave_pkg::ST_TX;
                            tx_r <= mem_q;
                            drive_r <= !mem_q[7];
                        end
                        else
                        begin
                            st_r <= eeprom_slave_pkg::ST_RX;
                            drive_r <= 1'b0;
                            kind_r <= (kind_r == eeprom_slave_pkg::K_SLAVE)
                                ? eeprom_slave_pkg::K_WADDR : eeprom_slave_pkg::K_WDATA;
                        end
                    end
                end
                eeprom_slave_pkg::ST_TX:
                begin
                    if (scl_rise)
                    begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                    else if (scl_fall)
                    begin
                        if (bit_cnt_r == eeprom_slave_pkg::BIT_DONE)
                        begin
                            st_r <= eeprom_slave_pkg::ST_MACK;
                            drive_r <= 1'b0;
                            addr_r <= addr_r + 11'h001;
                        end
                        else
                        begin
                            tx_r <= {tx_r[6:0], 1'b0};
                            drive_r <= !tx_r[6];
                        end
                    end
                end
                eeprom_slave_pkg::ST_MACK:
                begin
                    if (scl_rise)
                    begin
                        mack_r <= !sync2_r.sda;
                    end
                    else if (scl_fall)
                    begin
                        bit_cnt_r <= 4'h0;
                        if (mack_r)
                        begin
                            st_r <= eeprom_slave_pkg::ST_TX;
                            tx_r <= mem_q;
                            drive_r <= !mem_q[7];
                        end
                        else
                        begin
                            st_r <= eeprom_slave_pkg::ST_WAIT;
                            drive_r <= 1'b0;
                        end
                    end
                end
                default:
                begin
                    drive_r <= 1'b0;
                end
            endcase
        end
    end

    // page buffer; valid bits say which slots were loaded
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            valid_r <= 16'h0000;
        end
        else if (start_det && !busy_r)
        begin
            valid_r <= 16'h0000;
        end
        else if (buf_we)
        begin
            valid_r[addr_r[PW-1:0]] <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (buf_we)
        begin
            page_buf[addr_r[PW-1:0]] <= shift_r;
        end
    end

    // self-timed cycle: only the loaded slots are written early, the wait covers it all
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            busy_r <= 1'b0;
            twr_cnt_r <= '0;
            idx_r <= 5'h00;
            prog_page_r <= 7'h00;
        end
        else if (prog_go && !busy_r)
        begin
            busy_r <= 1'b1;
            twr_cnt_r <= '0;
            idx_r <= 5'h00;
            prog_page_r <= addr_r[AW-1:PW];
        end
        else if (busy_r)
        begin
            if (!idx_r[PW])
            begin
                idx_r <= idx_r + 5'h01;
            end
            if (twr_cnt_r == CNT_W'(TWR_CYC - 1))
            begin
                busy_r <= 1'b0;
            end
            else
            begin
                twr_cnt_r <= twr_cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // array write, one slot per cycle
    always_ff @(posedge clk_sys)
    begin
        if (busy_r && !idx_r[PW] && valid_r[idx_r[PW-1:0]])
        begin
            mem[{prog_page_r, idx_r[PW-1:0]}] <= page_buf[idx_r[PW-1:0]];
        end
    end

    a_start_begins: assert property (
        (start_det && !busy_r && !stop_det)
        |=> (st_r == eeprom_slave_pkg::ST_RX) && (bit_cnt_r == 4'h0) && sda_oe_n)
        else $error("start did not open a command");
    a_stop_idles: assert property (
        stop_det |=> (st_r == eeprom_slave_pkg::ST_IDLE) && sda_oe_n)
        else $error("stop did not end the command");
    a_addr_acked: assert property (
        (byte_end && (kind_r == eeprom_slave_pkg::K_SLAVE) && (shift_r[7:4] == DEV_CODE))
        |=> !sda_oe_n [*4])
        else $error("matching address not acknowledged");
    a_code_mismatch: assert property (
        (byte_end && (kind_r == eeprom_slave_pkg::K_SLAVE) && (shift_r[7:4] != DEV_CODE))
        |=> sda_oe_n && (st_r == eeprom_slave_pkg::ST_WAIT))
        else $error("foreign address answered");
    a_data_acked: assert property (
        buf_we |=> !sda_oe_n && (st_r == eeprom_slave_pkg::ST_ACK))
        else $error("write byte not acknowledged");
    a_busy_silent: assert property (
        busy_r && $past(busy_r) |-> sda_oe_n && (st_r == eeprom_slave_pkg::ST_IDLE))
        else $error("slave answered while programming");
    a_prog_starts: assert property (
        (prog_go && !busy_r) |=> busy_r ##1 busy_r)
        else $error("stop after data byte did not program");
    a_twr_bound: assert property (
        (busy_r && (twr_cnt_r == CNT_W'(TWR_CYC - 1))) |=> !busy_r)
        else $error("write cycle overran");
    a_page_wrap: assert property (
        buf_we |=> (addr_r[AW-1:PW] == $past(addr_r[AW-1:PW]))
            && (addr_r[PW-1:0] == 4'($past(addr_r[PW-1:0]) + 4'h1)))
        else $error("page pointer left its page");
    a_wp_cancel: assert property (
        (wp_cancel && !stop_det && !start_det)
        |=> (st_r == eeprom_slave_pkg::ST_IDLE) && !pending_r ##1 !busy_r || $past(busy_r))
        else $error("protect did not cancel write");
    a_read_nack: assert property (
        (st_r == eeprom_slave_pkg::ST_MACK) && scl_fall && !mack_r && !stop_det && !start_det
        && !wp_cancel |=> (st_r == eeprom_slave_pkg::ST_WAIT) && sda_oe_n)
        else $error("read continued after high acknowledge");
    a_seq_step: assert property (
        ((st_r == eeprom_slave_pkg::ST_TX) && scl_fall && !wp_cancel
        && (bit_cnt_r == eeprom_slave_pkg::BIT_DONE))
        |=> addr_r == 11'($past(addr_r) + 11'h001))
        else $error("read pointer did not step");

    c_random_read: cover property (
        (st_r == eeprom_slave_pkg::ST_ACK) && rd_r && scl_fall);
    c_seq_read: cover property (
        (st_r == eeprom_slave_pkg::ST_MACK) && mack_r && scl_fall);
    c_page_prog: cover property (prog_go && valid_r[0] && valid_r[15]);
    c_poll_refused: cover property (start_det && busy_r);

endmodule // eeprom_slave

// ===== tb/bus_master_model.sv
`timescale 1ns/100ps
// two-wire bus master; pins move only just after a system clock edge
module bus_master_model (
    input wire logic clk_sys,
    input wire logic sda_w,
    output logic scl,
    output logic sda
);
    // idle bus: both lines high, clock stands still between frames
    initial
    begin
        scl = 1'b1;
        sda = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // data changes mid low phase, sampled late in the high phase
    task automatic bit_io(input logic b, output logic r);
        tick(1);
        scl <= 1'b0;
        tick(2);
        sda <= b;
        tick(2);
        scl <= 1'b1;
        tick(3);
        r = sda_w;
    endtask

    // long low phase so a slave ack is gone before data rises
    task automatic start();
        tick(1);
        scl <= 1'b0;
        tick(4);
        sda <= 1'b1;
        tick(4);
        scl <= 1'b1;
        tick(4);
        sda <= 1'b0;
        tick(4);
    endtask

    task automatic stop();
        tick(1);
        scl <= 1'b0;
        tick(4);
        sda <= 1'b0;
        tick(4);
        scl <= 1'b1;
        tick(4);
        sda <= 1'b1;
        tick(4);
    endtask

    // eight bits msb first, then the ninth (ack) bit; a high ack ends a read
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
        output logic k);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(a, k);
    endtask
endmodule // bus_master_model

// ===== tb/tb_eeprom_slave.sv
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module tb_eeprom_slave;
    localparam int TWR = 200;
    localparam logic [3:0] CODE = 4'h9; // arbitrary device-type code
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic wp = 1'b0;
    logic scl, m_sda, sda_w, sda_out, sda_oe_n, prog_busy;
    int n_mismatch = 0;
    int n_tests = 0;
    logic [7:0] exp_q[$];

    always #12.5 clk_sys = ~clk_sys;
    // open drain wire: any party pulling low wins, pull-up otherwise
    assign sda_w = m_sda & (sda_oe_n ? 1'b1 : sda_out);

    bus_master_model mst (.clk_sys(clk_sys), .sda_w(sda_w), .scl(scl), .sda(m_sda));
    eeprom_slave #(.DEV_CODE(CODE), .TWR_CYC(TWR)) dut_u (.clk_sys(clk_sys), .nrst(nrst),
        .scl_in(scl), .sda_in(sda_w), .wp_in(wp), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .prog_busy(prog_busy));

    function automatic logic [7:0] sa(input logic [10:0] a, input logic rd_dir);
        return {CODE, a[10:8], rd_dir};
    endfunction

    task automatic final_report();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // protect is held high over the address bytes, where it must not matter
    task automatic wr(input logic [10:0] a, input int n, input logic [7:0] d0,
        input logic wpd);
        logic [7:0] q;
        logic k;
        @(posedge clk_sys) wp <= 1'b1;
        mst.start();
        mst.xfer(sa(a, 1'b0), 1'b1, q, k);
        `CHK(k, 1'b0)
        mst.xfer(a[7:0], 1'b1, q, k);
        `CHK(k, 1'b0)
        @(posedge clk_sys) wp <= wpd;
        for (int i = 0; i < n; i++)
        begin
            mst.xfer(d0 + 8'(i), 1'b1, q, k);
            `CHK(k, wpd)
        end
        mst.stop();
        @(posedge clk_sys) wp <= 1'b0;
        mst.tick(3);
        `CHK(prog_busy, ~wpd)
    endtask

    task automatic wait_idle();
        int cnt;
        cnt = 0;
        while (prog_busy === 1'b1 && cnt < TWR + 100)
        begin
            @(posedge clk_sys);
            cnt++;
        end
        `CHK(prog_busy, 1'b0)
        `CHK(cnt <= TWR, 1'b1)
        if (cnt >= TWR + 100)
        begin
            final_report();
        end
    endtask

    task automatic poll(input logic e);
        logic [7:0] q;
        logic k;
        mst.start();
        mst.xfer(sa(11'h000, 1'b0), 1'b1, q, k);
        `CHK(k, e)
        mst.stop();
    endtask

    // reads as many bytes as exp_q holds, the last one with a high ack
    task automatic rd(input logic [10:0] a, input logic cur);
        logic [7:0] q;
        logic k;
        if (!cur)
        begin
            mst.start();
            mst.xfer(sa(a, 1'b0), 1'b1, q, k);
            `CHK(k, 1'b0)
            mst.xfer(a[7:0], 1'b1, q, k);
            `CHK(k, 1'b0)
        end
        mst.start();
        mst.xfer(sa(a, 1'b1), 1'b1, q, k);
        `CHK(k, 1'b0)
        foreach (exp_q[i])
        begin
            mst.xfer(8'hff, i == exp_q.size() - 1, q, k);
            `CHK(q, exp_q[i])
        end
        mst.stop();
        `CHK(sda_oe_n, 1'b1)
        exp_q.delete();
    endtask

    task automatic t_byte_write();
        wr(11'h345, 1, 8'ha5, 1'b0);
        poll(1'b1);
        wait_idle();
        poll(1'b0);
        exp_q = '{8'ha5};
        rd(11'h345, 1'b0);
        $display("test byte_write done");
    endtask

    // 18 bytes from word 3e: the last two land at 3e and 3f again
    task automatic t_page_wrap();
        wr(11'h13e, 18, 8'h10, 1'b0);
        wait_idle();
        for (int j = 0; j < 15; j++)
            exp_q.push_back(j < 14 ? 8'h12 + 8'(j) : 8'h20);
        rd(11'h130, 1'b0);
        exp_q = '{8'h21};
        rd(11'h130, 1'b1);
        $display("test page_wrap done");
    endtask

    task automatic t_top_wrap();
        wr(11'h7ff, 1, 8'h5a, 1'b0);
        wait_idle();
        wr(11'h000, 1, 8'hc3, 1'b0);
        wait_idle();
        exp_q = '{8'h5a, 8'hc3};
        rd(11'h7ff, 1'b0);
        $display("test top_wrap done");
    endtask

    task automatic t_protect();
        wr(11'h200, 1, 8'h77, 1'b0);
        wait_idle();
        wr(11'h200, 1, 8'h88, 1'b1);
        exp_q = '{8'h77};
        rd(11'h200, 1'b0);
        $display("test protect done");
    endtask

    // foreign code, start-stop cancel and cut byte after data, then dummy clocks
    task automatic t_abort();
        logic [7:0] q;
        logic k;
        mst.start();
        mst.xfer({4'h6, 3'h3, 1'b0}, 1'b1, q, k);
        `CHK(k, 1'b1)
        mst.stop();
        mst.start();
        mst.xfer(sa(11'h345, 1'b0), 1'b1, q, k);
        mst.xfer(8'h45, 1'b1, q, k);
        mst.xfer(8'h3c, 1'b1, q, k);
        mst.start();
        mst.stop();
        mst.tick(3);
        `CHK(prog_busy, 1'b0)
        mst.start();
        mst.xfer(sa(11'h345, 1'b0), 1'b1, q, k);
        mst.xfer(8'h45, 1'b1, q, k);
        mst.xfer(8'h3c, 1'b1, q, k);
        repeat (4) mst.bit_io(1'b0, k);
        mst.stop();
        mst.tick(3);
        `CHK(prog_busy, 1'b0)
        mst.start();
        repeat (9) mst.bit_io(1'b1, k);
        exp_q = '{8'ha5};
        rd(11'h345, 1'b0);
        $display("test abort done");
    endtask

    // hang guard: far beyond the whole sequence
    initial
    begin
        #2000000;
        n_mismatch++;
        final_report();
    end

    initial
    begin
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        mst.tick(4);
        t_byte_write();
        t_page_wrap();
        t_top_wrap();
        t_protect();
        t_abort();
        final_report();
    end
endmodule // tb_eeprom_slave
